// >>> kbd_emul_map.vh
// register map, field positions and constants of the keyboard emulation block
//
// What this block does
// R1 - read-back bit shows gate A20 level
// R2 - aux IRQ12 rising edge sets W1C flag
// R3 - keyboard IRQ1 rising edge sets W1C flag
// R4 - host write D1h to 64h sets pending
// R5 - other value to 64h clears pending
// R6 - trap enable: edge flags raise emulation irq
// R7 - irq enable: legacy irq while output full
// R8 - aux full picks IRQ12, else IRQ1
// R9 - char pending raises irq when output empty
// R10 - emulation irq bit is pure decode
// R11 - emulation on claims ports 60h, 64h
// R12 - emulation on drives the emulation irq; legacy irqs ignore it
// R13 - host port write data lands in input buffer
// R14 - input buffer is software view of writes
// R15 - host read of 60h clears output full
// R16 - port write sets input full, except A20
// R17 - input full with emulation raises irq
// R18 - 60h write clears, 64h sets cmd flag
// R19 - A20 compare uses all eight bits
// R20 - reserved control bits read zero
`ifndef KBD_EMUL_MAP_VH
`define KBD_EMUL_MAP_VH

// register offsets, byte addresses
`define OFS_LEGACY_EMUL_CTRL 9'h100
`define OFS_LEGACY_IN_BUFFER 9'h104
`define OFS_LEGACY_EMUL_STAT 9'h10c

// control register fields
`define CTL_GATE_A20 8
`define CTL_AUX_EDGE 7
`define CTL_KBD_EDGE 6
`define CTL_A20_PEND 5
`define CTL_TRAP_EN 4
`define CTL_IRQ_GEN_EN 3
`define CTL_CHAR_PEND 2
`define CTL_EMUL_IRQ 1
`define CTL_EMUL_ON 0

// status register fields
`define STA_AUX_FULL 5
`define STA_CMD_DATA 3
`define STA_IN_FULL 1
`define STA_OUT_FULL 0

// reset values
`define RST_CTRL 32'h0000_0000
`define RST_IN_BUFFER 8'h00
`define RST_STAT 32'h0000_0000

// legacy i/o ports and the gate A20 command
`define PORT_KBD_DATA 16'h0060
`define PORT_KBD_CMD 16'h0064
`define A20_CMD_CODE 8'hd1

`endif

// >>> kbd_pin_sync.v
// three-stage pin synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/10ps
module kbd_pin_sync
(
    // clock and reset
    input wire clk_sys,
    input wire reset_n,
    // raw pins from the external controller
    input wire [2:0] pin_in,
    // filtered levels and rising-edge pulses
    output wire [2:0] level,
    output wire [2:0] rise
);

genvar i;
generate
    for (i = 0; i < 3; i = i + 1)
    begin : g_bit
        reg s1_reg;
        reg s2_reg;
        reg s3_reg;
        reg lvl_reg;
        reg rise_reg;
        // stage one feeds only stage two; level moves once two and three agree
        always @(posedge clk_sys or negedge reset_n)
        begin
            if (!reset_n)
            begin
                s1_reg <= 1'b0;
                s2_reg <= 1'b0;
                s3_reg <= 1'b0;
                lvl_reg <= 1'b0;
                rise_reg <= 1'b0;
            end
            else
            begin
                s1_reg <= pin_in[i];
                s2_reg <= s1_reg;
                s3_reg <= s2_reg;
                if (s2_reg == s3_reg)
                begin
                    lvl_reg <= s3_reg;
                end
                rise_reg <= (s2_reg == s3_reg) & s3_reg & ~lvl_reg;
            end
        end
        assign level[i] = lvl_reg;
        assign rise[i] = rise_reg;
    end
endgenerate

endmodule

// >>> kbd_port_decode.v
// decode of host i/o cycles to the legacy keyboard ports
`timescale 1ns/10ps
`include "kbd_emul_map.vh"
module kbd_port_decode
(
    // host i/o cycle
    input wire [15:0] io_addr,
    input wire [7:0] io_wdata,
    input wire io_wr,
    input wire io_rd,
    // emulation enable
    input wire emul_on,
    // decoded events
    output wire claim,
    output wire wr_data_port,
    output wire wr_cmd_port,
    output wire rd_data_port,
    output wire a20_cmd
);

wire hit_data;
wire hit_cmd;

// only claimed while emulation is on, so a real controller keeps the ports
assign hit_data = emul_on & (io_addr == `PORT_KBD_DATA); // R11
assign hit_cmd = emul_on & (io_addr == `PORT_KBD_CMD); // R11
assign claim = (io_wr | io_rd) & (hit_data | hit_cmd); // R11
assign wr_data_port = io_wr & hit_data;
assign wr_cmd_port = io_wr & hit_cmd;
assign rd_data_port = io_rd & hit_data;
// full byte compare, no partial match on the low bits
assign a20_cmd = (io_wdata == `A20_CMD_CODE); // R19

endmodule

// >>> kbd_emul_ctrl.v
// legacy keyboard controller emulation control: traps, flags and interrupts
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`include "kbd_emul_map.vh"
module kbd_emul_ctrl
(
    // clock and reset
    input wire clk_sys,
    input wire reset_n,
    // register port
    input wire [8:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // host legacy i/o cycles
    input wire [15:0] io_addr,
    input wire [7:0] io_wdata,
    input wire io_wr,
    input wire io_rd,
    output reg io_claim,
    // external keyboard controller pins
    input wire kbc_irq1,
    input wire kbc_irq12,
    input wire kbc_gate_a20,
    // interrupts out
    output reg legacy_irq1,
    output reg legacy_irq12,
    output reg emul_irq
);

////////////////////////////////////////////////////////////////////////////
// control and status state

reg legacy_emul_on_reg;
reg ext_kbc_irq_trap_en_reg;
reg legacy_irq_gen_en_reg;
reg char_pending_trigger_reg;
reg aux_irq_edge_seen_reg;
reg kbd_irq_edge_seen_reg;
reg a20_cmd_pending_reg;
reg [7:0] legacy_in_buffer_reg;
reg out_buffer_full_reg;
reg aux_out_full_reg;
reg in_buffer_full_reg;
reg cmd_data_select_reg;

reg aux_irq_edge_seen_next;
reg kbd_irq_edge_seen_next;
reg a20_cmd_pending_next;
reg [7:0] legacy_in_buffer_next;
reg out_buffer_full_next;
reg in_buffer_full_next;
reg cmd_data_select_next;
reg [31:0] reg_rdata_next;

wire [2:0] pin_level;
wire [2:0] pin_rise;
wire gate_a20_level;
wire claim;
wire wr_data_port;
wire wr_cmd_port;
wire rd_data_port;
wire a20_cmd;
wire wr_ctrl;
wire wr_inbuf;
wire wr_stat;
wire a20_seq_write;
wire emul_irq_flag;
wire irq1_next;
wire irq12_next;
wire [31:0] ctrl_view;
wire [31:0] stat_view;

// reset words as sized constants, so single fields can be picked out
localparam [31:0] ctrl_rst_val = `RST_CTRL;
localparam [31:0] stat_rst_val = `RST_STAT;

////////////////////////////////////////////////////////////////////////////
// submodules

// pins: bit 0 irq1, bit 1 irq12, bit 2 gate a20
kbd_pin_sync u_sync
(
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pin_in({kbc_gate_a20, kbc_irq12, kbc_irq1}),
    .level(pin_level),
    .rise(pin_rise)
);

kbd_port_decode u_decode
(
    .io_addr(io_addr),
    .io_wdata(io_wdata),
    .io_wr(io_wr),
    .io_rd(io_rd),
    .emul_on(legacy_emul_on_reg),
    .claim(claim),
    .wr_data_port(wr_data_port),
    .wr_cmd_port(wr_cmd_port),
    .rd_data_port(rd_data_port),
    .a20_cmd(a20_cmd)
);

assign gate_a20_level = pin_level[2]; // R1

////////////////////////////////////////////////////////////////////////////
// register strobes

assign wr_ctrl = reg_wr & (reg_addr == `OFS_LEGACY_EMUL_CTRL);
assign wr_inbuf = reg_wr & (reg_addr == `OFS_LEGACY_IN_BUFFER);
assign wr_stat = reg_wr & (reg_addr == `OFS_LEGACY_EMUL_STAT);

// the A20 command byte and its data byte do not reach the input buffer
// flag, so software never sees the gate sequence as keyboard traffic
assign a20_seq_write = (wr_cmd_port & a20_cmd) |
                       (wr_data_port & a20_cmd_pending_reg); // R16

////////////////////////////////////////////////////////////////////////////
// emulation interrupt: a pure decode of the live conditions, no storage

assign emul_irq_flag =
    (ext_kbc_irq_trap_en_reg &
        (kbd_irq_edge_seen_reg | aux_irq_edge_seen_reg)) | // R6
    (legacy_emul_on_reg & in_buffer_full_reg) | // R17 R12
    (char_pending_trigger_reg & ~out_buffer_full_reg); // R9 R10

// legacy interrupts follow output full while generation is enabled
assign irq1_next = legacy_irq_gen_en_reg & out_buffer_full_reg &
                   ~aux_out_full_reg; // R7 R8 R12
assign irq12_next = legacy_irq_gen_en_reg & out_buffer_full_reg &
                    aux_out_full_reg; // R7 R8 R12

////////////////////////////////////////////////////////////////////////////
// read views; reserved bits are zero

assign ctrl_view = {23'h000000,
                    gate_a20_level, // R1
                    aux_irq_edge_seen_reg,
                    kbd_irq_edge_seen_reg,
                    a20_cmd_pending_reg,
                    ext_kbc_irq_trap_en_reg,
                    legacy_irq_gen_en_reg,
                    char_pending_trigger_reg,
                    emul_irq_flag, // R10
                    legacy_emul_on_reg}; // R20

assign stat_view = {26'h0000000,
                    aux_out_full_reg,
                    1'b0,
                    cmd_data_select_reg,
                    1'b0,
                    in_buffer_full_reg,
                    out_buffer_full_reg};

////////////////////////////////////////////////////////////////////////////
// next-state of the flags; hardware set always beats a software clear

always @*
begin
    // keyboard edge flag, write one to clear
    kbd_irq_edge_seen_next = kbd_irq_edge_seen_reg;
    if (wr_ctrl && reg_wdata[`CTL_KBD_EDGE])
    begin
        kbd_irq_edge_seen_next = 1'b0; // R3
    end
    if (pin_rise[0])
    begin
        kbd_irq_edge_seen_next = 1'b1; // R3
    end

    // auxiliary edge flag, write one to clear
    aux_irq_edge_seen_next = aux_irq_edge_seen_reg;
    if (wr_ctrl && reg_wdata[`CTL_AUX_EDGE])
    begin
        aux_irq_edge_seen_next = 1'b0; // R2
    end
    if (pin_rise[1])
    begin
        aux_irq_edge_seen_next = 1'b1; // R2
    end

    // A20 sequence tracking, only port 64h writes move it
    a20_cmd_pending_next = a20_cmd_pending_reg;
    if (wr_cmd_port)
    begin
        a20_cmd_pending_next = a20_cmd; // R4 R5 R19
    end

    // command/data indicator
    cmd_data_select_next = cmd_data_select_reg;
    if (wr_data_port)
    begin
        cmd_data_select_next = 1'b0; // R18
    end
    else if (wr_cmd_port)
    begin
        cmd_data_select_next = 1'b1; // R18
    end

    // input buffer: host port write wins over a software write
    legacy_in_buffer_next = legacy_in_buffer_reg;
    if (wr_inbuf)
    begin
        legacy_in_buffer_next = reg_wdata[7:0]; // R14
    end
    if (wr_data_port || wr_cmd_port)
    begin
        legacy_in_buffer_next = io_wdata; // R13
    end

    // input full: software may clear, host write sets
    in_buffer_full_next = in_buffer_full_reg;
    if (wr_stat)
    begin
        in_buffer_full_next = reg_wdata[`STA_IN_FULL];
    end
    if ((wr_data_port || wr_cmd_port) && !a20_seq_write)
    begin
        in_buffer_full_next = 1'b1; // R16
    end

    // output full: software loads it, a host read of 60h empties it
    out_buffer_full_next = out_buffer_full_reg;
    if (wr_stat)
    begin
        out_buffer_full_next = reg_wdata[`STA_OUT_FULL];
    end
    if (rd_data_port)
    begin
        out_buffer_full_next = 1'b0; // R15
    end
end

////////////////////////////////////////////////////////////////////////////
// read data mux, answered in the cycle after the read strobe

always @*
begin
    reg_rdata_next = 32'h0000_0000;
    if (reg_rd)
    begin
        case (reg_addr)
            `OFS_LEGACY_EMUL_CTRL: reg_rdata_next = ctrl_view;
            `OFS_LEGACY_IN_BUFFER:
                reg_rdata_next = {24'h000000, legacy_in_buffer_reg};
            `OFS_LEGACY_EMUL_STAT: reg_rdata_next = stat_view;
            default: reg_rdata_next = 32'h0000_0000;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// software-owned control bits; reserved and read-only bits drop writes

always @(posedge clk_sys or negedge reset_n)
begin
    if (!reset_n)
    begin
        legacy_emul_on_reg <= ctrl_rst_val[`CTL_EMUL_ON];
        ext_kbc_irq_trap_en_reg <= ctrl_rst_val[`CTL_TRAP_EN];
        legacy_irq_gen_en_reg <= ctrl_rst_val[`CTL_IRQ_GEN_EN];
        char_pending_trigger_reg <= ctrl_rst_val[`CTL_CHAR_PEND];
        aux_out_full_reg <= stat_rst_val[`STA_AUX_FULL];
    end
    else
    begin
        if (wr_ctrl)
        begin
            legacy_emul_on_reg <= reg_wdata[`CTL_EMUL_ON]; // R11
            ext_kbc_irq_trap_en_reg <= reg_wdata[`CTL_TRAP_EN];
            legacy_irq_gen_en_reg <= reg_wdata[`CTL_IRQ_GEN_EN];
            char_pending_trigger_reg <= reg_wdata[`CTL_CHAR_PEND];
        end
        if (wr_stat)
        begin
            aux_out_full_reg <= reg_wdata[`STA_AUX_FULL];
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// hardware-updated flags and buffer

always @(posedge clk_sys or negedge reset_n)
begin
    if (!reset_n)
    begin
        kbd_irq_edge_seen_reg <= ctrl_rst_val[`CTL_KBD_EDGE];
        aux_irq_edge_seen_reg <= ctrl_rst_val[`CTL_AUX_EDGE];
        a20_cmd_pending_reg <= ctrl_rst_val[`CTL_A20_PEND];
        cmd_data_select_reg <= stat_rst_val[`STA_CMD_DATA];
        legacy_in_buffer_reg <= `RST_IN_BUFFER;
        in_buffer_full_reg <= stat_rst_val[`STA_IN_FULL];
        out_buffer_full_reg <= stat_rst_val[`STA_OUT_FULL];
    end
    else
    begin
        kbd_irq_edge_seen_reg <= kbd_irq_edge_seen_next;
        aux_irq_edge_seen_reg <= aux_irq_edge_seen_next;
        a20_cmd_pending_reg <= a20_cmd_pending_next;
        cmd_data_select_reg <= cmd_data_select_next;
        legacy_in_buffer_reg <= legacy_in_buffer_next;
        in_buffer_full_reg <= in_buffer_full_next;
        out_buffer_full_reg <= out_buffer_full_next;
    end
end

////////////////////////////////////////////////////////////////////////////
// registered outputs; each lags its condition by one clock

always @(posedge clk_sys or negedge reset_n)
begin
    if (!reset_n)
    begin
        reg_rdata <= 32'h0000_0000;
        io_claim <= 1'b0;
        legacy_irq1 <= 1'b0;
        legacy_irq12 <= 1'b0;
        emul_irq <= 1'b0;
    end
    else
    begin
        reg_rdata <= reg_rdata_next;
        io_claim <= claim; // R11
        legacy_irq1 <= irq1_next; // R8
        legacy_irq12 <= irq12_next; // R8
        emul_irq <= emul_irq_flag; // R12
    end
end

endmodule

// >>> kbd_emul_monitor.sv
// assertion checker for the keyboard emulation control block
`timescale 1ns/10ps
module kbd_emul_monitor
(
    // clock and reset
    input wire clk_sys,
    input wire reset_n,
    // register port
    input wire [8:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    // host i/o
    input wire [15:0] io_addr,
    input wire [7:0] io_wdata,
    input wire io_wr,
    input wire io_rd,
    input wire io_claim,
    // pins and interrupts
    input wire kbc_irq1,
    input wire kbc_irq12,
    input wire kbc_gate_a20,
    input wire legacy_irq1,
    input wire legacy_irq12,
    input wire emul_irq
);
reg on_reg;
reg gen_reg;
reg trap_reg;
reg chr_reg;
reg gate_last_reg;
reg [3:0] gate_cnt_reg;
wire port_hit = io_addr == 16'h0060 || io_addr == 16'h0064;
wire mapped = reg_addr == 9'h100 || reg_addr == 9'h104 || reg_addr == 9'h10c;
wire ctl_rd = reg_rd && reg_addr == 9'h100;
// no emulation interrupt source enabled at all
wire en_none = !on_reg && !trap_reg && !chr_reg;

////////////////////////////////////////////////////////////////////////////
// shadow of the enables, since the checker only sees the ports
always @(posedge clk_sys or negedge reset_n)
begin
    if (!reset_n)
    begin
        on_reg <= 1'b0;
        gen_reg <= 1'b0;
        trap_reg <= 1'b0;
        chr_reg <= 1'b0;
        gate_last_reg <= 1'b0;
        gate_cnt_reg <= 4'h0;
    end
    else
    begin
        if (reg_wr && reg_addr == 9'h100)
        begin
            on_reg <= reg_wdata[0];
            gen_reg <= reg_wdata[3];
            trap_reg <= reg_wdata[4];
            chr_reg <= reg_wdata[2];
        end
        gate_last_reg <= kbc_gate_a20;
        // a pin read is only trusted once the synchroniser has settled
        if (gate_last_reg != kbc_gate_a20)
            gate_cnt_reg <= 4'h0;
        else if (gate_cnt_reg != 4'h8)
            gate_cnt_reg <= gate_cnt_reg + 4'h1;
    end
end

////////////////////////////////////////////////////////////////////////////
default clocking mon_cb @(posedge clk_sys); endclocking
default disable iff (!reset_n);

rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside a read");
unmapped_zero_a: assert property (reg_rd && !mapped |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
ctrl_resv_a: assert property (ctl_rd |=> reg_rdata[31:9] == 23'h0)
    else $error("reserved control bits not zero");
inbuf_resv_a: assert property (reg_rd && reg_addr == 9'h104
    |=> reg_rdata[31:8] == 24'h0)
    else $error("input buffer upper bits not zero");
claim_hit_a: assert property ((io_wr || io_rd) && port_hit && on_reg
    |=> io_claim)
    else $error("legacy port access not claimed");
claim_miss_a: assert property (!(io_wr || io_rd) || !port_hit || !on_reg
    |=> !io_claim)
    else $error("claim without a legacy port access");
emul_quiet_a: assert property (en_none && $past(en_none) |-> !emul_irq)
    else $error("emulation interrupt with every source disabled");
irq_excl_a: assert property (!(legacy_irq1 && legacy_irq12))
    else $error("both legacy interrupts high");
irq_gen_off_a: assert property (!gen_reg && !$past(gen_reg)
    |-> !legacy_irq1 && !legacy_irq12)
    else $error("legacy interrupt while generation disabled");
gate_read_a: assert property (ctl_rd && gate_cnt_reg == 4'h8
    |=> reg_rdata[8] == $past(kbc_gate_a20))
    else $error("gate level bit differs from pin");
cmd_data_a: assert property (io_wr && io_addr == 16'h0060 && on_reg
    ##[1:3] reg_rd && reg_addr == 9'h10c |=> !reg_rdata[3])
    else $error("data port write left command flag set");
endmodule

bind kbd_emul_ctrl kbd_emul_monitor i_mon (.clk_sys(clk_sys),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
    .io_claim(io_claim), .kbc_irq1(kbc_irq1), .kbc_irq12(kbc_irq12),
    .kbc_gate_a20(kbc_gate_a20), .legacy_irq1(legacy_irq1),
    .legacy_irq12(legacy_irq12), .emul_irq(emul_irq));

// >>> kbd_host_model.sv
// host software model issuing legacy port i/o cycles
`timescale 1ns/10ps
module kbd_host_model
(
    // clock and request from the bench
    input wire clk_sys,
    input wire req,
    input wire req_wr,
    input wire [15:0] req_addr,
    input wire [7:0] req_data,
    // host i/o cycle
    output reg [15:0] io_addr = 16'h0000,
    output reg [7:0] io_wdata = 8'h00,
    output reg io_wr = 1'b0,
    output reg io_rd = 1'b0
);

////////////////////////////////////////////////////////////////////////////
// one-cycle strobes; idle bus toggles so stale values never look valid
always @(posedge clk_sys)
begin
    io_wr <= req && req_wr;
    io_rd <= req && !req_wr;
    io_addr <= req ? req_addr : ~io_addr;
    io_wdata <= req ? req_data : ~io_wdata;
end
endmodule

// >>> kbd_emul_ctrl_test.sv
// self-checking bench for the keyboard emulation control block
`timescale 1ns/10ps
`include "kbd_emul_map.vh"
module kbd_emul_ctrl_test;
localparam [8:0] A_CTL = `OFS_LEGACY_EMUL_CTRL;
localparam [8:0] A_INB = `OFS_LEGACY_IN_BUFFER;
localparam [8:0] A_STA = `OFS_LEGACY_EMUL_STAT;
reg clk_sys = 1'b0;
reg reset_n = 1'b0;
reg [8:0] reg_addr = 9'h0;
reg [31:0] reg_wdata = 32'h0;
reg reg_wr = 1'b0;
reg reg_rd = 1'b0;
reg kbc_irq1 = 1'b0;
reg kbc_irq12 = 1'b0;
reg kbc_gate_a20 = 1'b0;
reg req = 1'b0;
reg req_wr = 1'b0;
reg [15:0] req_addr = 16'h0;
reg [7:0] req_data = 8'h0;
wire [31:0] reg_rdata;
wire [15:0] io_addr;
wire [7:0] io_wdata;
wire io_wr, io_rd, io_claim, legacy_irq1, legacy_irq12, emul_irq;
integer mismatches = 0;
integer cmp_count = 0;
integer cycles = 0;
integer i;
reg [15:0] p;
reg [7:0] d;
reg [2:0] fl;
reg pend;

kbd_emul_ctrl i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_claim(io_claim),
    .kbc_irq1(kbc_irq1), .kbc_irq12(kbc_irq12), .kbc_gate_a20(kbc_gate_a20),
    .legacy_irq1(legacy_irq1), .legacy_irq12(legacy_irq12),
    .emul_irq(emul_irq));
kbd_host_model i_host (.clk_sys(clk_sys), .req(req), .req_wr(req_wr),
    .req_addr(req_addr), .req_data(req_data), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd));

////////////////////////////////////////////////////////////////////////////
// clock and hang guard
always #5 clk_sys = ~clk_sys;
always @(posedge clk_sys)
begin
    cycles = cycles + 1;
    if (cycles == 3000)
    begin
        mismatches = mismatches + 1;
        final_report;
    end
end

////////////////////////////////////////////////////////////////////////////
task final_report;
begin
    if (mismatches == 0 && cmp_count > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
end
endtask
task check_word(input [31:0] got, input [31:0] exp);
begin
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
        mismatches = mismatches + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
end
endtask
task check_bit(input got, input exp);
begin
    check_word({31'h0, got}, {31'h0, exp});
end
endtask
task reg_write(input [8:0] a, input [31:0] v);
begin
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
end
endtask
// read data stand only in the cycle after the strobe
task reg_read(input [8:0] a, input [31:0] m, input [31:0] e);
begin
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 check_word(reg_rdata & m, e);
end
endtask
task io_op(input w, input [15:0] a, input [7:0] v, input c);
begin
    @(posedge clk_sys);
    req <= 1'b1;
    req_wr <= w;
    req_addr <= a;
    req_data <= v;
    @(posedge clk_sys);
    req <= 1'b0;
    @(posedge clk_sys);
    #1 check_bit(io_claim, c);
end
endtask
// expected {pending, command flag, input full} after a port write
function [2:0] io_effect(input [15:0] pa, input [7:0] da, input pd);
begin
    if (pa == `PORT_KBD_CMD)
        io_effect = {da == `A20_CMD_CODE, 1'b1, da != `A20_CMD_CODE};
    else
        io_effect = {pd, 1'b0, !pd};
end
endfunction

////////////////////////////////////////////////////////////////////////////
initial
begin
    i = $urandom(32'hd1a6);
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    // reserved and read-only control bits ignore writes
    reg_write(A_CTL, 32'hffff_fe22);
    reg_read(A_CTL, 32'hffff_ffff, 32'h0);
    reg_read(9'h108, 32'hffff_ffff, 32'h0);
    reg_read(A_INB, 32'hffff_ffff, 32'h0);
    io_op(1'b1, `PORT_KBD_DATA, 8'h5a, 1'b0);
    reg_read(A_STA, 32'hffff_ffff, 32'h0);
    reg_write(A_CTL, 32'h1);
    pend = 1'b0;
    // corner codes first, near misses of the command differ in one bit
    for (i = 0; i < 12; i = i + 1)
    begin
        d = ($urandom % 4 == 0) ? `A20_CMD_CODE : $urandom;
        p = $urandom % 2 ? `PORT_KBD_CMD : `PORT_KBD_DATA;
        if (i == 0 || i == 3)
            {p, d} = {`PORT_KBD_CMD, `A20_CMD_CODE};
        if (i == 1)
            p = `PORT_KBD_DATA;
        if (i == 2 || i == 4)
            {p, d} = {`PORT_KBD_CMD, (i == 2) ? 8'h51 : 8'hd0};
        fl = io_effect(p, d, pend);
        pend = fl[2];
        reg_write(A_STA, 32'h0);
        io_op(1'b1, p, d, 1'b1);
        reg_read(A_STA, 32'ha, {28'h0, fl[1], 1'b0, fl[0], 1'b0});
        reg_read(A_CTL, 32'h22, {26'h0, fl[2], 3'h0, fl[0], 1'b0});
        reg_read(A_INB, 32'hffff_ffff, {24'h0, d});
        check_bit(emul_irq, fl[0]);
    end
    reg_write(A_STA, 32'h1);
    io_op(1'b0, `PORT_KBD_DATA, 8'h0, 1'b1);
    reg_read(A_STA, 32'h1, 32'h0);
    // every combination of aux and output full
    reg_write(A_CTL, 32'h9);
    for (i = 0; i < 4; i = i + 1)
    begin
        reg_write(A_STA, {26'h0, i[1], 4'h0, i[0]});
        repeat (2) @(posedge clk_sys);
        #1 check_bit(legacy_irq1, i[0] & !i[1]);
        check_bit(legacy_irq12, i[0] & i[1]);
    end
    reg_write(A_CTL, 32'h4);
    for (i = 0; i < 2; i = i + 1)
    begin
        reg_write(A_STA, i);
        repeat (2) @(posedge clk_sys);
        #1 check_bit(emul_irq, !i[0]);
    end
    // pin edges trap with emulation off; flags clear only by writing one
    reg_write(A_CTL, 32'h10);
    kbc_irq1 <= 1'b1;
    kbc_irq12 <= 1'b1;
    kbc_gate_a20 <= 1'b1;
    repeat (3) @(posedge clk_sys);
    kbc_irq1 <= 1'b0;
    kbc_irq12 <= 1'b0;
    repeat (8) @(posedge clk_sys);
    #1 check_bit(emul_irq, 1'b1);
    reg_read(A_CTL, 32'h1c0, 32'h1c0);
    reg_write(A_CTL, 32'h50);
    reg_read(A_CTL, 32'h1c0, 32'h180);
    reg_write(A_CTL, 32'h80);
    reg_read(A_CTL, 32'h1d2, 32'h100);
    final_report;
end
endmodule
